//--- pfm_pkg.sv
`default_nettype none
package pfm_pkg;
	// reset pin hold, in oscillator periods (clk is the oscillator)
	localparam int RST_HOLD_OSC = 64;
	localparam int RST_HOLD_CYC = RST_HOLD_OSC;
	// port reset value: latches high, pins released to pullups
	localparam logic [7:0] PORT_RST_VAL = 8'hff;
	// port 3 bit positions of the alternate functions
	localparam int P3_RXD = 0;
	localparam int P3_TXD = 1;
	localparam int P3_INT0 = 2;
	localparam int P3_INT1 = 3;
	localparam int P3_T0 = 4;
	localparam int P3_T1 = 5;
	localparam int P3_WR = 6;
	localparam int P3_RD = 7;
	// code range select bits in the first user configuration byte
	localparam int CFG_RNG_LO_POS = 2;
	localparam int CFG_RNG_HI_POS = 3;
	// serial mode 0 (shift register mode)
	localparam logic [1:0] SER_MODE0 = 2'h0;

	// timer 2 operating modes
	typedef enum logic [1:0] {
		PFM_T2_CAPTURE = 2'h0,
		PFM_T2_RELOAD = 2'h1,
		PFM_T2_UPDOWN = 2'h2,
		PFM_T2_CLKOUT = 2'h3
	} pfm_t2_mode_e;

	// power states, one-hot
	typedef enum logic [2:0] {
		PFM_PWR_RUN = 3'h1,
		PFM_PWR_IDLE = 3'h2,
		PFM_PWR_DOWN = 3'h4
	} pfm_pwr_e;

	// external bus phases, one-hot
	typedef enum logic [2:0] {
		PFM_BUS_IDLE = 3'h1,
		PFM_BUS_ADDR = 3'h2,
		PFM_BUS_DATA = 3'h4
	} pfm_bus_e;

	// code strobe window: 00 none, 01 low half, 10 high half, 11 all
	function automatic logic code_in_range(input logic [1:0] sel, input logic [15:0] addr);
		case (sel)
			2'h0: code_in_range = 1'b0;
			2'h1: code_in_range = ~addr[15];
			2'h2: code_in_range = addr[15];
			default: code_in_range = 1'b1;
		endcase
	endfunction
endpackage
`default_nettype wire

//--- pfm_fall_det.sv
`timescale 1ns/100ps
`default_nettype none
module pfm_fall_det #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] fall
);
	logic [W-1:0] prev_r;

	// one-cycle pulse on each high-to-low step of the pin
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_r <= {W{1'b1}};
			fall <= '0;
		end
		else
		begin
			prev_r <= pin;
			fall <= prev_r & ~pin;
		end
	end
endmodule
`default_nettype wire

//--- pfm_rst_filter.sv
`timescale 1ns/100ps
`default_nettype none
module pfm_rst_filter (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rst_pin,
	output logic core_rst
);
	logic [6:0] cnt_r;

	// count oscillator periods with the pin high; short glitches do nothing
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r <= '0;
			core_rst <= 1'b0;
		end
		else if (!rst_pin)
		begin
			cnt_r <= '0;
			core_rst <= 1'b0;
		end
		else if (cnt_r == 7'(pfm_pkg::RST_HOLD_CYC - 1))
			core_rst <= 1'b1;
		else
			cnt_r <= cnt_r + 7'h01;
	end
endmodule
`default_nettype wire

//--- pfm_pin_map.sv
// Overview of operation
// - port 3 is an 8-bit pulled-up port carrying serial, irq, timer, strobes
// - code read strobe asserts only inside the range chosen by two config bits
// - data read strobe goes low while reading external data memory
// - write strobe goes low while writing external memory
// - reset pin high for 64 oscillator periods resets the device
// - reset pin high forces port pins to reset state, clock or not
// - reset pin raised in idle or powerdown returns to normal running
// - serial mode 0: transmit pin gives shift clock, receive pin is two-way
// - serial modes 1 to 3: receive pin only receives, transmit pin sends data
// - in counter mode each falling count-input edge increments timer 0 or 1
// - timer 2 clock pin is clock input in capture, clock output in clock-out
// - timer 2 capture mode: trigger falling edge starts a capture
// - timer 2 auto-reload mode: trigger falling edge reloads timer 2
// - timer 2 up/down mode: trigger high counts up, low counts down
// - page mode: port 0 low address, port 2 high address and data
// - all internal timing comes from the oscillator input
// - irq flags set by falling edge if edge select set, else by low level
// - non-page mode: port 0 multiplexes low address and data, port 2 high address
`timescale 1ns/100ps
`default_nettype none
module pfm_pin_map (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rst_pin,
	output logic core_rst,
	input wire logic idle_req,
	input wire logic pdown_req,
	output logic idle_active,
	output logic pdown_active,
	input wire logic [7:0] user_config_byte_zero,
	input wire logic page_mode,
	input wire logic [7:0] p0_latch,
	input wire logic [7:0] p2_latch,
	input wire logic [7:0] p3_latch,
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe,
	input wire logic [7:0] p2_in,
	output logic [7:0] p2_out,
	output logic [7:0] p2_oe,
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe,
	output logic [7:0] p3_pins_r,
	input wire logic code_rd_req,
	input wire logic data_rd_req,
	input wire logic data_wr_req,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic bus_busy,
	output logic bus_done,
	output logic [7:0] bus_rdata,
	output logic ale,
	output logic code_read_strobe_n,
	input wire logic [1:0] ser_mode,
	input wire logic ser_m0_clk,
	input wire logic ser_m0_dout,
	input wire logic ser_m0_drive,
	input wire logic ser_txd,
	output logic ser_rxd,
	input wire logic [1:0] ext_irq_edge_sel,
	input wire logic [1:0] ext_irq_clr,
	output logic [1:0] ext_irq_flags,
	input wire logic [1:0] timer01_count_mode,
	output logic [1:0] timer01_count_tick,
	input wire logic [1:0] t2_mode,
	input wire logic t2_clkout_val,
	input wire logic timer2_clock_pin_in,
	output logic timer2_clock_pin_out,
	output logic timer2_clock_pin_oe,
	input wire logic timer2_trigger_pin,
	output logic t2_ext_tick,
	output logic t2_capture,
	output logic t2_reload,
	output logic t2_count_up
);
	pfm_pkg::pfm_pwr_e pwr_r;
	pfm_pkg::pfm_bus_e bus_r;
	pfm_pkg::pfm_t2_mode_e t2m;
	logic [1:0] kind_r, irq_fall, cnt_fall, rng_sel;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] p0_r, p0e_r, p2_r, p2e_r, p3_r, p3_alt;
	logic rd_n_r, wr_n_r, code_read_strobe_n_r;
	logic t2_fall, timer2_trigger_pin_fall, take;
	logic [6:0] hold_r;

	// the whole block runs on clk, which is the oscillator input
	assign t2m = pfm_pkg::pfm_t2_mode_e'(t2_mode);
	assign rng_sel = {user_config_byte_zero[pfm_pkg::CFG_RNG_HI_POS], user_config_byte_zero[pfm_pkg::CFG_RNG_LO_POS]};
	assign take = bus_r == pfm_pkg::PFM_BUS_IDLE && !core_rst && pwr_r == pfm_pkg::PFM_PWR_RUN;
	assign bus_busy = bus_r != pfm_pkg::PFM_BUS_IDLE;

	// reset pin filter and falling edge detectors
	pfm_rst_filter u_rst (
		.clk(clk),
		.resetn(resetn),
		.rst_pin(rst_pin),
		.core_rst(core_rst)
	);
	pfm_fall_det #(.W(2)) u_irq (
		.clk(clk),
		.resetn(resetn),
		.pin(p3_in[pfm_pkg::P3_INT1:pfm_pkg::P3_INT0]),
		.fall(irq_fall)
	);
	pfm_fall_det #(.W(2)) u_cnt (
		.clk(clk),
		.resetn(resetn),
		.pin(p3_in[pfm_pkg::P3_T1:pfm_pkg::P3_T0]),
		.fall(cnt_fall)
	);
	pfm_fall_det #(.W(2)) u_t2 (
		.clk(clk),
		.resetn(resetn),
		.pin({timer2_trigger_pin, timer2_clock_pin_in}),
		.fall({timer2_trigger_pin_fall, t2_fall})
	);

	// power state; a reset pin level wakes from idle and powerdown
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pwr_r <= pfm_pkg::PFM_PWR_RUN;
		else
			case (pwr_r)
				pfm_pkg::PFM_PWR_RUN:
				begin
					if (!rst_pin && pdown_req)
						pwr_r <= pfm_pkg::PFM_PWR_DOWN;
					else if (!rst_pin && idle_req)
						pwr_r <= pfm_pkg::PFM_PWR_IDLE;
				end
				pfm_pkg::PFM_PWR_IDLE, pfm_pkg::PFM_PWR_DOWN:
				begin
					if (rst_pin)
						pwr_r <= pfm_pkg::PFM_PWR_RUN;
				end
				default: pwr_r <= pfm_pkg::PFM_PWR_RUN;
			endcase
	end
	assign idle_active = pwr_r == pfm_pkg::PFM_PWR_IDLE;
	assign pdown_active = pwr_r == pfm_pkg::PFM_PWR_DOWN;

	// external bus sequencer: one address cycle, one strobe cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus_r <= pfm_pkg::PFM_BUS_IDLE;
			kind_r <= 2'h0;
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
		end
		else
			case (bus_r)
				pfm_pkg::PFM_BUS_IDLE:
				begin
					if (take && (code_rd_req || data_rd_req || data_wr_req))
					begin
						bus_r <= pfm_pkg::PFM_BUS_ADDR;
						kind_r <= code_rd_req ? 2'h0 : (data_rd_req ? 2'h1 : 2'h2);
						addr_r <= bus_addr;
						wdata_r <= bus_wdata;
					end
				end
				pfm_pkg::PFM_BUS_ADDR: bus_r <= pfm_pkg::PFM_BUS_DATA;
				pfm_pkg::PFM_BUS_DATA: bus_r <= pfm_pkg::PFM_BUS_IDLE;
				default: bus_r <= pfm_pkg::PFM_BUS_IDLE;
			endcase
	end

	// strobes, ale and read capture; port 3 strobes start a cycle early, the port 3 flop delays them
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			code_read_strobe_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			ale <= 1'b0;
			bus_done <= 1'b0;
			bus_rdata <= 8'h00;
		end
		else
		begin
			ale <= take && (code_rd_req || data_rd_req || data_wr_req);
			code_read_strobe_n_r <= !(bus_r == pfm_pkg::PFM_BUS_ADDR && kind_r == 2'h0 &&
				pfm_pkg::code_in_range(rng_sel, addr_r));
			rd_n_r <= !(take && !code_rd_req && data_rd_req);
			wr_n_r <= !(take && !code_rd_req && !data_rd_req && data_wr_req);
			bus_done <= bus_r == pfm_pkg::PFM_BUS_DATA;
			if (bus_r == pfm_pkg::PFM_BUS_DATA && kind_r != 2'h2)
				bus_rdata <= page_mode ? p2_in : p0_in;
		end
	end

	// ports 0 and 2: address/data during bus cycles, latches otherwise
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			p0_r <= pfm_pkg::PORT_RST_VAL;
			p0e_r <= 8'h00;
			p2_r <= pfm_pkg::PORT_RST_VAL;
			p2e_r <= 8'h00;
		end
		else if (take && (code_rd_req || data_rd_req || data_wr_req))
		begin
			p0_r <= bus_addr[7:0];
			p0e_r <= 8'hff;
			p2_r <= bus_addr[15:8];
			p2e_r <= 8'hff;
		end
		else if (bus_r == pfm_pkg::PFM_BUS_ADDR && page_mode)
		begin
			p2_r <= wdata_r;
			p2e_r <= {8{kind_r == 2'h2}};
		end
		else if (bus_r == pfm_pkg::PFM_BUS_ADDR)
		begin
			p0_r <= wdata_r;
			p0e_r <= {8{kind_r == 2'h2}};
		end
		else if (bus_r != pfm_pkg::PFM_BUS_DATA)
		begin
			p0_r <= p0_latch;
			p0e_r <= ~p0_latch;
			p2_r <= p2_latch;
			p2e_r <= ~p2_latch;
		end
	end

	// alternate outputs on port 3, idle high so the latch alone rules
	always_comb
	begin
		p3_alt = 8'hff;
		if (ser_mode == pfm_pkg::SER_MODE0)
		begin
			p3_alt[pfm_pkg::P3_RXD] = ser_m0_drive ? ser_m0_dout : 1'b1;
			p3_alt[pfm_pkg::P3_TXD] = ser_m0_clk;
		end
		else
			p3_alt[pfm_pkg::P3_TXD] = ser_txd;
		p3_alt[pfm_pkg::P3_WR] = wr_n_r;
		p3_alt[pfm_pkg::P3_RD] = rd_n_r;
	end

	// port 3 pin drive: latch and function combined, pullups give the high
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			p3_r <= pfm_pkg::PORT_RST_VAL;
			p3_pins_r <= pfm_pkg::PORT_RST_VAL;
			ser_rxd <= 1'b1;
		end
		else
		begin
			p3_r <= p3_latch & p3_alt;
			p3_pins_r <= p3_in;
			ser_rxd <= p3_in[pfm_pkg::P3_RXD];
		end
	end

	// reset pin forces every port to its reset state without any clock
	always_comb
	begin
		p0_out = rst_pin ? pfm_pkg::PORT_RST_VAL : p0_r;
		p0_oe = rst_pin ? 8'h00 : p0e_r;
		p2_out = rst_pin ? pfm_pkg::PORT_RST_VAL : p2_r;
		p2_oe = rst_pin ? 8'h00 : p2e_r;
		p3_out = rst_pin ? pfm_pkg::PORT_RST_VAL : p3_r;
		p3_oe = rst_pin ? 8'h00 : ~p3_r;
		code_read_strobe_n = rst_pin | code_read_strobe_n_r;
		timer2_clock_pin_out = rst_pin | t2_clkout_val;
		timer2_clock_pin_oe = !rst_pin && t2m == pfm_pkg::PFM_T2_CLKOUT;
	end

	// external interrupt flags; a new event wins over a clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ext_irq_flags <= 2'h0;
		else
			for (int i = 0; i < 2; i++)
				if (ext_irq_edge_sel[i] ? irq_fall[i] : !p3_in[pfm_pkg::P3_INT0 + i])
					ext_irq_flags[i] <= 1'b1;
				else if (ext_irq_clr[i])
					ext_irq_flags[i] <= 1'b0;
	end

	// counter ticks for timers 0, 1 and 2, trigger events of timer 2
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timer01_count_tick <= 2'h0;
			t2_ext_tick <= 1'b0;
			t2_capture <= 1'b0;
			t2_reload <= 1'b0;
			t2_count_up <= 1'b1;
		end
		else
		begin
			timer01_count_tick <= cnt_fall & timer01_count_mode;
			t2_ext_tick <= t2_fall && t2m == pfm_pkg::PFM_T2_CAPTURE;
			t2_capture <= timer2_trigger_pin_fall && t2m == pfm_pkg::PFM_T2_CAPTURE;
			t2_reload <= timer2_trigger_pin_fall && t2m == pfm_pkg::PFM_T2_RELOAD;
			t2_count_up <= t2m != pfm_pkg::PFM_T2_UPDOWN || timer2_trigger_pin;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// consecutive reset pin samples, saturating, watched by the filter checks
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			hold_r <= 7'h00;
		else
			hold_r <= rst_pin ? hold_r + 7'(hold_r != 7'h7f) : 7'h00;

	sequence s_rst_held;
		rst_pin [*8];
	endsequence
	sequence s_bus_start;
		take && !code_rd_req && data_wr_req && !data_rd_req;
	endsequence

	a_rst_filter_len: assert property (core_rst |-> hold_r >= 7'(pfm_pkg::RST_HOLD_CYC))
		else $error("core reset too early");
	a_rst_filter_on: assert property (hold_r >= 7'(pfm_pkg::RST_HOLD_CYC) |-> core_rst)
		else $error("core reset missing after hold");
	a_rst_force_port: assert property (rst_pin |-> p0_oe == 8'h00 && p2_oe == 8'h00 && p3_oe == 8'h00)
		else $error("port driven during reset pin");
	a_rst_wake: assert property (s_rst_held |-> pwr_r == pfm_pkg::PFM_PWR_RUN)
		else $error("reset pin did not wake");
	a_wr_strobe: assert property (s_bus_start |-> ##1 !p3_alt[pfm_pkg::P3_WR] ##1 p3_alt[pfm_pkg::P3_WR])
		else $error("write strobe timing wrong");
	a_rd_strobe: assert property (take && data_rd_req && !code_rd_req |-> ##1 !rd_n_r ##1 rd_n_r)
		else $error("read strobe timing wrong");
	a_code_range: assert property (!code_read_strobe_n |-> pfm_pkg::code_in_range(rng_sel, addr_r))
		else $error("code strobe outside range");
	a_p3_latch_rule: assert property (p3_latch[pfm_pkg::P3_TXD] == 1'b0 |=> !p3_r[pfm_pkg::P3_TXD])
		else $error("latch zero overridden");
	a_irq_edge: assert property (ext_irq_edge_sel[0] && irq_fall[0] |=> ext_irq_flags[0])
		else $error("edge irq flag not set");
	a_t2_capture: assert property (timer2_trigger_pin_fall && t2m == pfm_pkg::PFM_T2_CAPTURE |=> t2_capture && !t2_reload)
		else $error("capture not started");
	a_t2_reload: assert property (timer2_trigger_pin_fall && t2m == pfm_pkg::PFM_T2_RELOAD |=> t2_reload)
		else $error("reload not started");
	a_t2_dir: assert property (t2m == pfm_pkg::PFM_T2_UPDOWN && !timer2_trigger_pin |=> !t2_count_up)
		else $error("count direction wrong");
	a_cnt_tick: assert property (cnt_fall[1] && timer01_count_mode[1] |=> timer01_count_tick[1])
		else $error("counter tick lost");
	a_m0_txd: assert property (ser_mode == pfm_pkg::SER_MODE0 |-> p3_alt[pfm_pkg::P3_TXD] == ser_m0_clk)
		else $error("mode 0 shift clock missing");
	a_m1_rxd: assert property (ser_mode != pfm_pkg::SER_MODE0 |-> p3_alt[pfm_pkg::P3_RXD])
		else $error("receive pin driven");
	a_page_addr: assert property ((s_bus_start and page_mode) |=> p0_oe == 8'hff && p2_out == $past(bus_addr[15:8]))
		else $error("page mode address wrong");
	a_mux_data: assert property ((s_bus_start and !page_mode) ##1 1'b1 |=> p0_out == wdata_r)
		else $error("multiplexed data missing");
	a_t2_clkout: assert property (!rst_pin && t2m == pfm_pkg::PFM_T2_CLKOUT |-> timer2_clock_pin_oe)
		else $error("clock out not driven");
endmodule
`default_nettype wire

//--- pfm_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfm_mem_model (
	input wire logic clk,
	input wire logic page_mode,
	input wire logic ale,
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p2_out,
	input wire logic [7:0] p3_pin,
	input wire logic code_read_strobe_n,
	output logic [7:0] mem_drv,
	output logic mem_en
);
	logic [7:0] mem [256];
	logic [15:0] addr_r;
	logic [7:0] last_r;
	// preload a pattern so unwritten bytes are still known
	initial
	begin
		last_r = 8'h00;
		addr_r = 16'h0000;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end
	// latch address at the marker, store data while the write strobe is low
	always @(posedge clk)
	begin
		if (ale)
			addr_r <= {p2_out, p0_out};
		if (!p3_pin[6])
			mem[addr_r[7:0]] <= page_mode ? p2_out : p0_out;
		if (mem_en)
			last_r <= mem_drv;
	end
	// drive only under a read strobe, otherwise show a flipped stale byte
	assign mem_en = !p3_pin[7] || !code_read_strobe_n;
	assign mem_drv = mem_en ? mem[addr_r[7:0]] : ~last_r;
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk, resetn, rst_pin, idle_req, pdown_req, page_mode, code_rd_req, data_rd_req, data_wr_req;
	logic [7:0] cfg, p0_latch, p2_latch, p3_latch, p3_ext, bus_wdata;
	logic [15:0] bus_addr;
	logic [1:0] ser_mode, edge_sel, irq_clr, cnt_mode, t2_mode;
	logic m0_clk, m0_dout, m0_drive, ser_txd, clkout_val, t2_ext, trig;
	logic [7:0] p0_in, p0_out, p0_oe, p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, rdata, mem_drv, p3_pins;
	logic core_rst, idle_active, pdown_active, bus_busy, bus_done, ale, crs_n, ser_rxd, mem_en;
	logic [1:0] irq_flags, cnt_tick;
	logic t2_pin_out, t2_pin_oe, t2_pin, t2_tick, t2_cap, t2_rel, t2_up;
	int error_cnt = 0, total_checks = 0, cyc = 0, c_t0, c_t1, c_cap, c_rel, c_ext, sc;
	logic [7:0] rd;
	// pin levels from every driver; undriven port 2/3 pins float high
	assign p0_in = (p0_oe & p0_out) | (~p0_oe & (page_mode ? 8'hff : mem_drv));
	assign p2_in = (p2_oe & p2_out) | (~p2_oe & (page_mode && mem_en ? mem_drv : 8'hff));
	assign p3_in = (p3_oe & p3_out) | (~p3_oe & p3_ext);
	assign t2_pin = t2_pin_oe ? t2_pin_out : t2_ext;
	pfm_pin_map uut (.clk(clk), .resetn(resetn), .rst_pin(rst_pin), .core_rst(core_rst), .idle_req(idle_req),
		.pdown_req(pdown_req), .idle_active(idle_active), .pdown_active(pdown_active),
		.user_config_byte_zero(cfg), .page_mode(page_mode), .p0_latch(p0_latch), .p2_latch(p2_latch),
		.p3_latch(p3_latch), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p2_in(p2_in), .p2_out(p2_out),
		.p2_oe(p2_oe), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pins_r(p3_pins),
		.code_rd_req(code_rd_req),
		.data_rd_req(data_rd_req), .data_wr_req(data_wr_req), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_busy(bus_busy), .bus_done(bus_done), .bus_rdata(rdata), .ale(ale), .code_read_strobe_n(crs_n),
		.ser_mode(ser_mode), .ser_m0_clk(m0_clk), .ser_m0_dout(m0_dout), .ser_m0_drive(m0_drive),
		.ser_txd(ser_txd), .ser_rxd(ser_rxd), .ext_irq_edge_sel(edge_sel), .ext_irq_clr(irq_clr),
		.ext_irq_flags(irq_flags), .timer01_count_mode(cnt_mode), .timer01_count_tick(cnt_tick),
		.t2_mode(t2_mode), .t2_clkout_val(clkout_val), .timer2_clock_pin_in(t2_pin),
		.timer2_clock_pin_out(t2_pin_out), .timer2_clock_pin_oe(t2_pin_oe), .timer2_trigger_pin(trig),
		.t2_ext_tick(t2_tick), .t2_capture(t2_cap), .t2_reload(t2_rel), .t2_count_up(t2_up));
	pfm_mem_model mem (.clk(clk), .page_mode(page_mode), .ale(ale), .p0_out(p0_out), .p2_out(p2_out),
		.p3_pin(p3_in), .code_read_strobe_n(crs_n), .mem_drv(mem_drv), .mem_en(mem_en));
	// clock at 20 ns period
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	task finish_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// count pulses of the event outputs over n cycles
	task watch(input int n);
		c_t0 = 0; c_t1 = 0; c_cap = 0; c_rel = 0; c_ext = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			c_t0 += int'(cnt_tick[0] === 1'b1);
			c_t1 += int'(cnt_tick[1] === 1'b1);
			c_cap += int'(t2_cap === 1'b1);
			c_rel += int'(t2_rel === 1'b1);
			c_ext += int'(t2_tick === 1'b1);
		end
	endtask
	// one bus cycle: k 0 code read, 1 data read, 2 write; sc counts strobe-low cycles
	task bus_op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		int na;
		logic dn;
		na = 0; dn = 1'b0; sc = 0;
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		code_rd_req <= (k == 2'h0);
		data_rd_req <= (k == 2'h1);
		data_wr_req <= (k == 2'h2);
		@(posedge clk);
		code_rd_req <= 1'b0;
		data_rd_req <= 1'b0;
		data_wr_req <= 1'b0;
		for (int i = 0; i < 8 && !dn; i++)
		begin
			#1;
			if (ale === 1'b1)
			begin
				na++;
				chk("addr_lo", {8'h00, a[7:0]}, {8'h00, p0_out});
				chk("addr_hi", {8'h00, a[15:8]}, {8'h00, p2_out});
				chk("bus_busy", 16'h0001, {15'h0000, bus_busy});
			end
			if ((k == 2'h0 && crs_n === 1'b0) || (k == 2'h1 && p3_in[7] === 1'b0) || (k == 2'h2 && p3_in[6] === 1'b0))
				sc++;
			if (bus_done === 1'b1)
			begin
				dn = 1'b1;
				rd = rdata;
			end
			else
				@(posedge clk);
		end
		chk("ale_count", 16'h0001, 16'(na));
		chk("bus_done", 16'h0001, {15'h0000, dn});
	endtask
	task t_bus(input logic pg, input logic [15:0] a, input logic [7:0] d);
		page_mode <= pg;
		bus_op(2'h2, a, d);
		chk("wr_strobe", 16'h0001, 16'(sc));
		bus_op(2'h1, a, 8'h00);
		chk("rd_strobe", 16'h0001, 16'(sc));
		chk("rd_data", {8'h00, d}, {8'h00, rd});
	endtask
	task t_code();
		logic [15:0] a;
		for (int s = 0; s < 4; s++)
			for (int h = 0; h < 2; h++)
			begin
				a = h ? 16'h9234 : 16'h1234;
				cfg <= {4'h0, 2'(s), 2'h0};
				bus_op(2'h0, a, 8'h00);
				chk("code_strobe", 16'(s == 3 || (s == 1 && !h) || (s == 2 && h)), 16'(sc));
			end
	endtask
	task t_latch();
		p3_latch <= 8'hbf;
		bus_op(2'h2, 16'h0077, 8'h11);
		chk("wr_masked", 16'h0003, 16'(sc));
		p3_latch <= 8'hff;
	endtask
	task t_rst(input logic pd);
		@(posedge clk);
		idle_req <= !pd;
		pdown_req <= pd;
		@(posedge clk);
		idle_req <= 1'b0;
		pdown_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("low_power", 16'h0001, {15'h0000, pd ? pdown_active : idle_active});
		@(posedge clk);
		rst_pin <= 1'b1;
		#1;
		chk("p3_oe_forced", 16'h0000, {8'h00, p3_oe});
		repeat (63) @(posedge clk);
		#1;
		chk("core_rst_63", 16'h0000, {15'h0000, core_rst});
		@(posedge clk);
		#1;
		chk("core_rst_64", 16'h0001, {15'h0000, core_rst});
		@(posedge clk);
		rst_pin <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("back_to_run", 16'h0000, {14'h0000, idle_active, pdown_active});
	endtask
	task t_irq();
		edge_sel <= 2'h1;
		p3_ext[2] <= 1'b0;
		p3_ext[3] <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("irq_set", 16'h0003, {14'h0000, irq_flags});
		@(posedge clk);
		irq_clr <= 2'h3;
		p3_ext[3] <= 1'b1;
		@(posedge clk);
		irq_clr <= 2'h0;
		repeat (3) @(posedge clk);
		#1;
		chk("irq_clear", 16'h0000, {14'h0000, irq_flags});
		p3_ext[2] <= 1'b1;
	endtask
	task t_tmr();
		@(posedge clk);
		cnt_mode <= 2'h3;
		p3_ext[4] <= 1'b0;
		watch(5);
		chk("t0_tick", 16'h0010, 16'(c_t0 * 16 + c_t1));
		p3_ext[5] <= 1'b0;
		watch(5);
		chk("t1_tick", 16'h0001, 16'(c_t0 * 16 + c_t1));
		t2_mode <= 2'h0;
		trig <= 1'b0;
		t2_ext <= 1'b0;
		watch(5);
		chk("t2_capture", 16'h0111, 16'(c_cap * 256 + c_ext * 16 + c_rel * 16 + c_cap));
		t2_mode <= 2'h1;
		trig <= 1'b1;
		watch(2);
		trig <= 1'b0;
		watch(5);
		chk("t2_reload", 16'h0010, 16'(c_rel * 16 + c_cap));
		t2_mode <= 2'h2;
		watch(3);
		chk("t2_down", 16'h0000, {15'h0000, t2_up});
		trig <= 1'b1;
		watch(3);
		chk("t2_up", 16'h0001, {15'h0000, t2_up});
		t2_mode <= 2'h3;
		t2_ext <= 1'b1;
		clkout_val <= 1'b0;
		watch(3);
		chk("t2_clkout", 16'h0000, {15'h0000, t2_pin});
	endtask
	task t_ser();
		@(posedge clk);
		ser_mode <= 2'h0;
		m0_clk <= 1'b0;
		m0_drive <= 1'b1;
		m0_dout <= 1'b0;
		watch(3);
		chk("m0_pins", 16'h0000, {14'h0000, p3_in[1:0]});
		ser_mode <= 2'h1;
		ser_txd <= 1'b0;
		m0_clk <= 1'b1;
		watch(3);
		chk("m1_pins", 16'h0001, {14'h0000, p3_in[1:0]});
		p3_ext[0] <= 1'b0;
		watch(3);
		chk("rxd_in", 16'h0000, {15'h0000, ser_rxd});
		chk("p3_pins", 16'h00cc, {8'h00, p3_pins});
		p3_ext[0] <= 1'b1;
		ser_txd <= 1'b1;
	endtask
	// main sequence
	initial
	begin
		resetn = 1'b0; rst_pin = 1'b0; idle_req = 1'b0; pdown_req = 1'b0; page_mode = 1'b0; cfg = 8'h0c;
		p0_latch = 8'hff; p2_latch = 8'hff; p3_latch = 8'hff; p3_ext = 8'hff; bus_addr = 16'h0000;
		bus_wdata = 8'h00; code_rd_req = 1'b0; data_rd_req = 1'b0; data_wr_req = 1'b0; ser_mode = 2'h1;
		m0_clk = 1'b1; m0_dout = 1'b1; m0_drive = 1'b0; ser_txd = 1'b1; edge_sel = 2'h0; irq_clr = 2'h0;
		cnt_mode = 2'h0; t2_mode = 2'h2; clkout_val = 1'b1; t2_ext = 1'b1; trig = 1'b1;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("p3_idle", 16'h00ff, {8'h00, p3_in});
		t_bus(1'b0, 16'h0012, 8'ha5);
		t_bus(1'b1, 16'h3456, 8'h3c);
		page_mode <= 1'b0;
		t_code();
		t_latch();
		t_rst(1'b0);
		t_rst(1'b1);
		t_irq();
		t_tmr();
		t_ser();
		finish_test();
	end
endmodule
`default_nettype wire
